/* File: valve_pkg.sv */
package valve_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_ACCESS_MODE = 6'h00;
    localparam logic [5:0] ADDR_CTRL_MODE   = 6'h04;
    localparam logic [5:0] ADDR_DIN_CFG     = 6'h08;
    localparam logic [5:0] ADDR_DOUT_CFG    = 6'h0c;
    localparam logic [5:0] ADDR_SERVICE     = 6'h10;
    localparam logic [5:0] ADDR_STATUS      = 6'h14;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int DIN_FIELD_W  = 8;
    localparam int DOUT_FIELD_W = 8;
    localparam int CFG_EN_POS   = 0;
    localparam int CFG_INV_POS  = 1;
    localparam int CFG_FN_POS   = 2;
    localparam int SVC_RECOVER_POS = 0;
    localparam int SVC_RESTART_POS = 1;
    localparam int SVC_PF_OPEN_POS = 2;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_LOCAL  = 2'h0,
        ACC_REMOTE = 2'h1,
        ACC_LOCKED = 2'h2
    } access_e;

    localparam access_e ACCESS_RESET = ACC_REMOTE;

    typedef enum logic [3:0] {
        CM_INIT      = 4'h0,
        CM_HOMING    = 4'h1,
        CM_POSITION  = 4'h2,
        CM_CLOSE     = 4'h3,
        CM_OPEN      = 4'h4,
        CM_PRESSURE  = 4'h5,
        CM_HOLD      = 4'h6,
        CM_LEARN     = 4'h7,
        CM_ILK_OPEN  = 4'h8,
        CM_ILK_CLOSE = 4'h9,
        CM_PWR_FAIL  = 4'ha,
        CM_SAFETY    = 4'hb,
        CM_ERROR     = 4'hc
    } ctrl_mode_e;

    localparam logic [1:0] DIN_FN_ILK_OPEN  = 2'h0;
    localparam logic [1:0] DIN_FN_ILK_CLOSE = 2'h1;
    localparam logic [1:0] DIN_FN_HOLD      = 2'h2;

    localparam logic [1:0] DOUT_FN_OPEN   = 2'h0;
    localparam logic [1:0] DOUT_FN_CLOSED = 2'h1;
    localparam logic [1:0] DOUT_FN_HOLD   = 2'h2;

    localparam logic [7:0] DIN_CFG_RESET  = 8'h01;
    localparam logic [7:0] DOUT_CFG_RESET = 8'h01;

    // ------------------------------------------------------------------
    // Valve drive command
    // ------------------------------------------------------------------
    typedef struct packed {
        logic motor_en;
        logic go_open;
        logic go_close;
        logic go_position;
        logic go_pressure;
        logic hold;
        logic run_homing;
        logic run_learn;
    } drive_s;

endpackage

/* File: valve_mode_ctrl.sv */
// Behaviour
// - Exactly one source, remote or service tool, owns control at a time.
// - In Remote the service tool may switch access to Local.
// - In Locked a service tool request for Local is refused.
// - Access mode is Remote after reset.
// - Service link loss in Local returns access to Remote.
// - Mode write is a request; mode read returns the actual state.
// - Init after reset until homing starts, an interlock input acts or an exception occurs.
// - Pressure mode regulates pressure; Position mode moves to target.
// - Hold keeps position; Close straight to Hold is refused.
// - Interlock-open input opens and locks the valve.
// - Interlock-open release goes to Open if homed, else Init.
// - Interlock-close input closes and locks the valve.
// - Interlock-close release goes to Close if homed, else Init.
// - Interlocks override remote commands; hold input does not.
// - Both interlocks active: close wins.
// - Safety input removes all motor drive; power loss with option outranks it.
// - Safety release moves the state to Init.
// - Error state inhibits all valve movement.
// - Error left only by recovery or restart service command, or by power loss with option.
// - Power loss with option enters Power Failure, opens or closes.
`timescale 1ns/1ps

module valve_mode_ctrl
#(
    parameter int N_DIN  = 2,
    parameter int N_DOUT = 2,
    parameter bit PF_OPTION = 1'b1
) (
    // Clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 srst,
    input  wire logic                 clk_en,
    // Avalon-MM slave
    input  wire logic [5:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    output logic [31:0]               avs_readdata,
    output logic                      avs_waitrequest,
    // Remote interface master
    input  wire logic                 remote_mode_req,
    input  wire logic [3:0]           remote_mode_val,
    // Service tool
    input  wire logic                 service_link_up,
    input  wire logic                 service_local_req,
    input  wire logic                 service_remote_req,
    // Valve status and events
    input  wire logic                 homing_done,
    input  wire logic                 learn_done,
    input  wire logic                 fault_event,
    input  wire logic                 safety_in,
    input  wire logic                 power_lost,
    input  wire logic                 valve_is_open,
    input  wire logic                 valve_is_closed,
    // Digital pins
    input  wire logic [N_DIN-1:0]     din_pin,
    output logic [N_DOUT-1:0]         dout_pin,
    // Valve drive
    output valve_pkg::drive_s         drive
);

    import valve_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    access_e                      access_r;
    ctrl_mode_e                   mode_r;
    ctrl_mode_e                   mode_nxt;
    logic                         homed_r;
    logic                         pf_open_r;
    logic [N_DIN*DIN_FIELD_W-1:0] din_cfg_r;
    logic [N_DOUT*DOUT_FIELD_W-1:0] dout_cfg_r;
    logic [N_DIN-1:0]             din_state;
    logic [N_DOUT-1:0]            dout_state;
    logic                         ilk_open;
    logic                         ilk_close;
    logic                         hold_in;
    logic                         sw_req;
    logic [3:0]                   sw_val;
    logic                         svc_recover;
    logic                         svc_restart;
    logic                         bus_wr;
    logic                         bus_rd;

    // ------------------------------------------------------------------
    // Bus slave: one wait cycle on every access
    // ------------------------------------------------------------------
    assign bus_wr = avs_write && !avs_waitrequest && clk_en;
    assign bus_rd = avs_read && !avs_waitrequest && clk_en;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            // Answer on the edge after the request is seen
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            avs_readdata <= 32'h0;
        end else if (clk_en && avs_read && avs_waitrequest) begin
            // Loaded in the wait cycle, stands until next read
            unique case (avs_address)
                ADDR_ACCESS_MODE: avs_readdata <= {30'h0, access_r};
                ADDR_CTRL_MODE:   avs_readdata <= {28'h0, mode_r};
                ADDR_DIN_CFG:     avs_readdata <= 32'(din_cfg_r);
                ADDR_DOUT_CFG:    avs_readdata <= 32'(dout_cfg_r);
                ADDR_SERVICE:     avs_readdata <= {29'h0, pf_open_r, 2'h0};
                ADDR_STATUS:      avs_readdata <= {16'(dout_state),
                                                   8'(din_state),
                                                   7'h0, homed_r};
                default:          avs_readdata <= 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            din_cfg_r  <= {N_DIN{DIN_CFG_RESET}};
            dout_cfg_r <= {N_DOUT{DOUT_CFG_RESET}};
            pf_open_r  <= 1'b0;
        end else if (bus_wr) begin
            if (avs_address == ADDR_DIN_CFG) begin
                din_cfg_r <= avs_writedata[N_DIN*DIN_FIELD_W-1:0];
            end
            if (avs_address == ADDR_DOUT_CFG) begin
                dout_cfg_r <= avs_writedata[N_DOUT*DOUT_FIELD_W-1:0];
            end
            if (avs_address == ADDR_SERVICE) begin
                pf_open_r <= avs_writedata[SVC_PF_OPEN_POS];
            end
        end
    end

    assign svc_recover = bus_wr && avs_address == ADDR_SERVICE
                         && avs_writedata[SVC_RECOVER_POS];
    assign svc_restart = bus_wr && avs_address == ADDR_SERVICE
                         && avs_writedata[SVC_RESTART_POS];

    // ------------------------------------------------------------------
    // Access arbitration
    // ------------------------------------------------------------------
    // Link loss outranks all requests: a pulled cable
    // always hands control back to the remote master
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            access_r <= ACCESS_RESET;
        end else if (clk_en) begin
            if (access_r == ACC_LOCAL && !service_link_up) begin
                access_r <= ACC_REMOTE;
            end else if (service_local_req && service_link_up
                         && access_r == ACC_REMOTE) begin
                access_r <= ACC_LOCAL;
            end else if (service_remote_req && access_r == ACC_LOCAL) begin
                access_r <= ACC_REMOTE;
            end else if (bus_wr && avs_address == ADDR_ACCESS_MODE
                         && access_r != ACC_LOCAL) begin
                if (avs_writedata[1:0] == ACC_LOCKED) begin
                    access_r <= ACC_LOCKED;
                end else if (avs_writedata[1:0] == ACC_REMOTE) begin
                    access_r <= ACC_REMOTE;
                end
            end
        end
    end

    // Only the current owner's mode request passes
    always_comb begin
        if (access_r == ACC_LOCAL) begin
            sw_req = bus_wr && avs_address == ADDR_CTRL_MODE;
            sw_val = avs_writedata[3:0];
        end else begin
            sw_req = remote_mode_req && clk_en;
            sw_val = remote_mode_val;
        end
    end

    // ------------------------------------------------------------------
    // Digital inputs
    // ------------------------------------------------------------------
    // Functions act on the inverted state, not the pin
    // Hold is decoded but never overrides a request
    always_comb begin
        ilk_open  = 1'b0;
        ilk_close = 1'b0;
        hold_in   = 1'b0;
        for (int i = 0; i < N_DIN; i++) begin
            din_state[i] = din_pin[i]
                ^ din_cfg_r[i*DIN_FIELD_W+CFG_INV_POS];
            if (din_cfg_r[i*DIN_FIELD_W+CFG_EN_POS] && din_state[i]) begin
                unique case (din_cfg_r[i*DIN_FIELD_W+CFG_FN_POS +: 2])
                    DIN_FN_ILK_OPEN:  ilk_open  = 1'b1;
                    DIN_FN_ILK_CLOSE: ilk_close = 1'b1;
                    DIN_FN_HOLD:      hold_in   = 1'b1;
                    default:          ;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Control mode state machine
    // ------------------------------------------------------------------
    // Restart forgets the home position
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            homed_r <= 1'b0;
        end else if (clk_en) begin
            if (mode_r == CM_HOMING && homing_done) begin
                homed_r <= 1'b1;
            end else if (svc_restart) begin
                homed_r <= 1'b0;
            end
        end
    end

    // Exceptions, then interlocks, then the owner's request;
    // a request the state cannot take is dropped
    always_comb begin
        mode_nxt = mode_r;
        if (PF_OPTION && power_lost) begin
            mode_nxt = CM_PWR_FAIL;
        end else if (mode_r == CM_ERROR) begin
            if (svc_recover || svc_restart) begin
                mode_nxt = CM_INIT;
            end
        end else if (fault_event) begin
            mode_nxt = CM_ERROR;
        end else if (safety_in) begin
            mode_nxt = CM_SAFETY;
        end else if (mode_r == CM_SAFETY) begin
            mode_nxt = CM_INIT;
        end else if (ilk_close) begin
            mode_nxt = CM_ILK_CLOSE;
        end else if (ilk_open) begin
            mode_nxt = CM_ILK_OPEN;
        end else if (mode_r == CM_ILK_CLOSE) begin
            mode_nxt = homed_r ? CM_CLOSE : CM_INIT;
        end else if (mode_r == CM_ILK_OPEN) begin
            mode_nxt = homed_r ? CM_OPEN : CM_INIT;
        end else if (mode_r == CM_PWR_FAIL) begin
            mode_nxt = CM_INIT;
        end else if (mode_r == CM_HOMING && homing_done) begin
            mode_nxt = CM_CLOSE;
        end else if (mode_r == CM_LEARN && learn_done) begin
            mode_nxt = CM_PRESSURE;
        end else if (sw_req) begin
            unique case (ctrl_mode_e'(sw_val))
                CM_HOMING: mode_nxt = CM_HOMING;
                CM_HOLD: begin
                    if (mode_r != CM_CLOSE && homed_r) begin
                        mode_nxt = CM_HOLD;
                    end
                end
                CM_POSITION, CM_CLOSE, CM_OPEN, CM_PRESSURE,
                CM_LEARN: begin
                    if (homed_r) begin
                        mode_nxt = ctrl_mode_e'(sw_val);
                    end
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_r <= CM_INIT;
        end else if (clk_en) begin
            mode_r <= mode_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Valve drive
    // ------------------------------------------------------------------
    // Built from the next state so it moves with mode_r
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            drive <= '0;
        end else if (clk_en) begin
            drive <= '0;
            unique case (mode_nxt)
                CM_HOMING:    drive.run_homing  <= 1'b1;
                CM_POSITION:  drive.go_position <= 1'b1;
                CM_PRESSURE:  drive.go_pressure <= 1'b1;
                CM_HOLD:      drive.hold        <= 1'b1;
                CM_LEARN:     drive.run_learn   <= 1'b1;
                CM_OPEN, CM_ILK_OPEN: drive.go_open <= 1'b1;
                CM_CLOSE, CM_ILK_CLOSE: drive.go_close <= 1'b1;
                CM_PWR_FAIL: begin
                    drive.go_open  <= pf_open_r;
                    drive.go_close <= !pf_open_r;
                end
                default: ;
            endcase
            drive.motor_en <= !(mode_nxt inside {CM_SAFETY, CM_ERROR,
                                                 CM_INIT});
        end
    end

    // ------------------------------------------------------------------
    // Digital outputs
    // ------------------------------------------------------------------
    // Enable gates the function before inversion
    always_comb begin
        for (int j = 0; j < N_DOUT; j++) begin
            unique case (dout_cfg_r[j*DOUT_FIELD_W+CFG_FN_POS +: 2])
                DOUT_FN_OPEN:   dout_state[j] = valve_is_open;
                DOUT_FN_CLOSED: dout_state[j] = valve_is_closed;
                DOUT_FN_HOLD:   dout_state[j] = mode_r == CM_HOLD;
                default:        dout_state[j] = 1'b0;
            endcase
            dout_state[j] = dout_state[j]
                && dout_cfg_r[j*DOUT_FIELD_W+CFG_EN_POS];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dout_pin <= '0;
        end else if (clk_en) begin
            for (int k = 0; k < N_DOUT; k++) begin
                dout_pin[k] <= dout_state[k]
                    ^ dout_cfg_r[k*DOUT_FIELD_W+CFG_INV_POS];
            end
        end
    end

endmodule // valve_mode_ctrl

/* File: valve_mode_ctrl_assertions.sv */
`timescale 1ns/1ps

module valve_mode_ctrl_assertions
    import valve_pkg::*;
#(
    parameter int N_DOUT    = 2,
    parameter bit PF_OPTION = 1'b1
) (
    input wire logic              ref_clk,
    input wire logic              srst,
    input wire logic              clk_en,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic [31:0]       avs_readdata,
    input wire logic              avs_waitrequest,
    input wire logic              fault_event,
    input wire logic              safety_in,
    input wire logic              power_lost,
    input wire logic [N_DOUT-1:0] dout_pin,
    input wire drive_s            drive
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest && clk_en;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    AST_BUS_ANSWER: assert property (s_taken |=> s_answer)
        else $error("bus answer missing");
    AST_BUS_CAUSE: assert property ($fell(avs_waitrequest)
        |-> $past(avs_read || avs_write)) else $error("answer without request");
    AST_RDATA_HOLD: assert property (!avs_read |=> $stable(avs_readdata))
        else $error("read data moved without read");
    AST_RESET_IDLE: assert property ($fell(srst) |-> drive == '0
        && avs_waitrequest && dout_pin == '0) else $error("not idle after reset");
    AST_SAFETY_NO_MOTOR: assert property (safety_in && !power_lost
        && clk_en |-> ##[1:2] !drive.motor_en) else $error("motor on in safety");
    AST_ERROR_STILL: assert property (fault_event && !power_lost
        && clk_en |-> ##[1:2] drive == '0) else $error("drive in error");
    AST_PF_MOVE: assert property (PF_OPTION && power_lost && clk_en
        |-> ##[1:2] (drive.go_open || drive.go_close))
        else $error("no move on power loss");
    AST_FREEZE: assert property (!clk_en |=> $stable(drive)
        && $stable(dout_pin)) else $error("state moved while frozen");
endmodule // valve_mode_ctrl_assertions

bind valve_mode_ctrl valve_mode_ctrl_assertions #(
    .N_DOUT(N_DOUT), .PF_OPTION(PF_OPTION)
) u_chk (
    .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fault_event(fault_event), .safety_in(safety_in),
    .power_lost(power_lost), .dout_pin(dout_pin), .drive(drive)
);

/* File: service_tool_model.sv */
`timescale 1ns/1ps

module service_tool_model (
    input  wire logic ref_clk,
    input  wire logic srst,
    input  wire logic plug_in,
    input  wire logic ask_local,
    output logic      service_link_up,
    output logic      service_local_req,
    output logic      service_remote_req
);
    // Requests only travel while the cable is in
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            service_link_up    <= 1'b0;
            service_local_req  <= 1'b0;
            service_remote_req <= 1'b0;
        end else begin
            service_link_up    <= plug_in;
            service_local_req  <= ask_local && plug_in;
            service_remote_req <= 1'b0;
        end
    end
endmodule // service_tool_model

/* File: valve_mode_ctrl_test.sv */
`timescale 1ns/1ps

module valve_mode_ctrl_test;
    import valve_pkg::*;
    logic        ref_clk, srst, clk_en, avs_read, avs_write, avs_waitrequest;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic        remote_mode_req, link_up, local_req, remote_req;
    logic [3:0]  remote_mode_val;
    logic        plug_in, ask_local, homing_done, fault_event;
    logic        safety_in, power_lost, valve_is_open, valve_is_closed;
    logic [1:0]  din_pin, dout_pin;
    drive_s      drive;
    int          miscompares, checks_done, seed;
    ctrl_mode_e  seq_m [4] = '{CM_POSITION, CM_PRESSURE, CM_HOLD, CM_OPEN};

    valve_mode_ctrl #(.N_DIN(2), .N_DOUT(2), .PF_OPTION(1'b1)) u_dut (
        .ref_clk(ref_clk), .srst(srst), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .remote_mode_req(remote_mode_req), .remote_mode_val(remote_mode_val),
        .service_link_up(link_up), .service_local_req(local_req),
        .service_remote_req(remote_req), .homing_done(homing_done),
        .learn_done(1'b0), .fault_event(fault_event), .safety_in(safety_in),
        .power_lost(power_lost), .valve_is_open(valve_is_open),
        .valve_is_closed(valve_is_closed), .din_pin(din_pin),
        .dout_pin(dout_pin), .drive(drive)
    );
    service_tool_model u_tool (
        .ref_clk(ref_clk), .srst(srst), .plug_in(plug_in),
        .ask_local(ask_local), .service_link_up(link_up),
        .service_local_req(local_req), .service_remote_req(remote_req)
    );

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic final_report;
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [5:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            miscompares++;
            final_report();
        end
        rd = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        cmp(rd, e);
    endtask
    task automatic w4;
        repeat (4) @(posedge ref_clk);
    endtask
    task automatic remote(input logic [3:0] m);
        @(posedge ref_clk);
        remote_mode_req <= 1'b1;
        remote_mode_val <= m;
        @(posedge ref_clk);
        remote_mode_req <= 1'b0;
        w4();
    endtask
    task automatic tool_ask;
        @(posedge ref_clk);
        ask_local <= 1'b1;
        @(posedge ref_clk);
        ask_local <= 1'b0;
        w4();
    endtask
    task automatic pulse_fault;
        @(posedge ref_clk);
        fault_event <= 1'b1;
        @(posedge ref_clk);
        fault_event <= 1'b0;
        w4();
    endtask
    function automatic logic [31:0] md(input ctrl_mode_e m);
        return {28'h0, m};
    endfunction
    function automatic logic [31:0] release_to(input logic homed,
                                               input ctrl_mode_e ilk);
        if (!homed)
            return md(CM_INIT);
        return md(ilk == CM_ILK_CLOSE ? CM_CLOSE : CM_OPEN);
    endfunction
    function automatic logic mode_bit(input ctrl_mode_e m, input drive_s d);
        case (m)
            CM_POSITION: return d.go_position;
            CM_PRESSURE: return d.go_pressure;
            CM_HOLD:     return d.hold;
            default:     return d.go_open;
        endcase
    endfunction

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        final_report();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        seed = 32'he892;
        miscompares = 0;
        checks_done = 0;
        {srst, clk_en} = 2'h3;
        {avs_read, avs_write, remote_mode_req, plug_in, ask_local} = 5'h0;
        {homing_done, fault_event, safety_in, power_lost} = 4'h0;
        {valve_is_open, valve_is_closed, din_pin} = 4'h0;
        {avs_address, avs_writedata, remote_mode_val} = '0;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
        rd_chk(ADDR_ACCESS_MODE, {30'h0, ACC_REMOTE});
        rd_chk(ADDR_CTRL_MODE, md(CM_INIT));
        rd_chk(6'h3c, 32'h0);
        rd_chk(ADDR_DIN_CFG, {16'h0, DIN_CFG_RESET, DIN_CFG_RESET});
        plug_in <= 1'b1;
        tool_ask();
        rd_chk(ADDR_ACCESS_MODE, {30'h0, ACC_LOCAL});
        remote(CM_HOMING);
        rd_chk(ADDR_CTRL_MODE, md(CM_INIT));
        bus(1'b1, ADDR_CTRL_MODE, md(CM_HOMING));
        rd_chk(ADDR_CTRL_MODE, md(CM_HOMING));
        plug_in <= 1'b0;
        w4();
        rd_chk(ADDR_ACCESS_MODE, {30'h0, ACC_REMOTE});
        homing_done <= 1'b1;
        w4();
        homing_done <= 1'b0;
        remote(CM_HOLD);
        rd_chk(ADDR_CTRL_MODE, md(CM_CLOSE));
        bus(1'b1, ADDR_ACCESS_MODE, {30'h0, ACC_LOCKED});
        plug_in <= 1'b1;
        tool_ask();
        rd_chk(ADDR_ACCESS_MODE, {30'h0, ACC_LOCKED});
        plug_in <= 1'b0;
        bus(1'b1, ADDR_ACCESS_MODE, {30'h0, ACC_REMOTE});
        foreach (seq_m[i]) begin
            remote(seq_m[i]);
            rd_chk(ADDR_CTRL_MODE, md(seq_m[i]));
            cmp({31'h0, mode_bit(seq_m[i], drive)}, 32'h1);
        end
        valve_is_open <= 1'b1;
        w4();
        cmp({30'h0, dout_pin}, 32'h3);
        bus(1'b1, ADDR_DOUT_CFG, 32'h0503);
        w4();
        cmp({30'h0, dout_pin}, 32'h0);
        {valve_is_open, valve_is_closed} <= 2'b01;
        w4();
        cmp({30'h0, dout_pin}, 32'h3);
        bus(1'b0, ADDR_STATUS, 32'h0);
        cmp({30'h0, rd[17:16]}, 32'h2);
        bus(1'b1, ADDR_DIN_CFG, 32'h0501);
        din_pin <= 2'b01;
        w4();
        rd_chk(ADDR_CTRL_MODE, md(CM_ILK_OPEN));
        cmp({31'h0, drive.go_open}, 32'h1);
        remote(CM_POSITION);
        rd_chk(ADDR_CTRL_MODE, md(CM_ILK_OPEN));
        din_pin <= 2'b11;
        w4();
        rd_chk(ADDR_CTRL_MODE, md(CM_ILK_CLOSE));
        cmp({31'h0, drive.go_close}, 32'h1);
        din_pin <= 2'b00;
        w4();
        rd_chk(ADDR_CTRL_MODE, release_to(1'b1, CM_ILK_CLOSE));
        din_pin <= 2'b01;
        w4();
        din_pin <= 2'b00;
        w4();
        rd_chk(ADDR_CTRL_MODE, release_to(1'b1, CM_ILK_OPEN));
        bus(1'b1, ADDR_DIN_CFG, 32'h050b);
        remote(CM_POSITION);
        rd_chk(ADDR_CTRL_MODE, md(CM_POSITION));
        bus(1'b0, ADDR_STATUS, 32'h0);
        cmp({31'h0, rd[8]}, 32'h1);
        bus(1'b1, ADDR_DIN_CFG, 32'h0500);
        din_pin <= 2'b01;
        w4();
        rd_chk(ADDR_CTRL_MODE, md(CM_POSITION));
        din_pin <= 2'b00;
        safety_in <= 1'b1;
        w4();
        rd_chk(ADDR_CTRL_MODE, md(CM_SAFETY));
        safety_in <= 1'b0;
        w4();
        rd_chk(ADDR_CTRL_MODE, md(CM_INIT));
        clk_en <= 1'b0;
        w4();
        clk_en <= 1'b1;
        for (int k = 0; k < 2; k++) begin
            pulse_fault();
            rd_chk(ADDR_CTRL_MODE, md(CM_ERROR));
            cmp({24'h0, drive}, 32'h0);
            repeat (3) begin
                remote(4'(unsigned'($random(seed)) % 12));
                rd_chk(ADDR_CTRL_MODE, md(CM_ERROR));
            end
            bus(1'b1, ADDR_SERVICE, 32'h1 << (k + SVC_RECOVER_POS));
            w4();
            rd_chk(ADDR_CTRL_MODE, md(CM_INIT));
        end
        for (int pf = 0; pf < 2; pf++) begin
            bus(1'b1, ADDR_SERVICE, 32'(pf) << SVC_PF_OPEN_POS);
            power_lost <= 1'b1;
            w4();
            rd_chk(ADDR_CTRL_MODE, md(CM_PWR_FAIL));
            cmp({31'h0, pf ? drive.go_open : drive.go_close}, 32'h1);
            power_lost <= 1'b0;
            w4();
        end
        final_report();
    end
endmodule // valve_mode_ctrl_test
